/* grsa_cell.sv */
// One 8-bit storage location with a per-bit writable mask
module grsa_cell #(
  parameter logic [7:0] WR_MASK = 8'hFF
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // Write side
  input  wire logic       i_we,
  input  wire logic [7:0] i_wdata,
  // Stored value
  output logic      [7:0] o_q
);
  logic [7:0] q_ff;
  logic [7:0] nxt_q;

  assign nxt_q = i_we ? ((i_wdata & WR_MASK) | (q_ff & ~WR_MASK)) : q_ff;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      q_ff <= grsa_pkg::REG_RESET;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign o_q = q_ff;
endmodule

/* grsa_pkg.sv */
package grsa_pkg;
  // Register space geometry
  localparam int          ADDR_W          = 6;
  localparam int          DATA_W          = 8;
  localparam int          NUM_REGS        = 64;
  localparam logic [5:0]  ADDR_LAST       = 6'h3F;
  // Read-only low range
  localparam logic [5:0]  RO_LAST         = 6'h0E;
  // Trigger locations
  localparam logic [5:0]  SOFT_RESTART    = 6'h14;
  localparam logic [5:0]  LATCH_CTRL      = 6'h21;
  localparam int          LATCH_CLR_BIT   = 7;
  localparam logic [7:0]  SOFT_RESTART_KEY = 8'hB6;
  // Queue read port
  localparam logic [5:0]  QUEUE_PORT      = 6'h3F;
  localparam logic [7:0]  QUEUE_RESET     = 8'h00;
  localparam logic [7:0]  REG_RESET       = 8'h00;
  // Bus answer timing: read data returned one cycle after the request
  localparam int          RD_WAIT_CYC     = 1;
endpackage

/* grsa_regs.sv */
// Summary of operation
// - Every location holds eight bits; transfers move whole bytes.
// - Sixty-four flat addresses, 0x00 to 0x3F, are decoded.
// - Writes to reserved bits are discarded; reserved reads undefined.
// - Addresses 0x00 to 0x0E are read-only; writes change nothing.
// - Trigger bits are write-only and always read as zero.
//
// The implementer's own choice: register access over Avalon-MM.
module grsa_regs #(
  parameter int unsigned RESERVED_MASK_HI = 32'h0000_0000
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // Avalon-MM slave
  input  wire logic [5:0] i_avs_address,
  input  wire logic       i_avs_read,
  input  wire logic       i_avs_write,
  input  wire logic [7:0] i_avs_writedata,
  output logic      [7:0] o_avs_readdata,
  output logic            o_avs_waitrequest,
  // Device state for the read-only range
  input  wire logic [7:0] i_status [15],
  // Queue read port
  input  wire logic [7:0] i_queue_data,
  output logic            o_queue_pop,
  // Trigger pulses
  output logic            o_soft_restart,
  output logic            o_latch_clear
);
  localparam int NREG = grsa_pkg::NUM_REGS;

  // Decode and cell widths are fixed at 64 x 8, so refuse any other geometry
  if (grsa_pkg::DATA_W != 8 || grsa_pkg::ADDR_W != 6 || grsa_pkg::NUM_REGS != 64) begin : g_bad_geometry
    $error("register space must be 64 x 8");
  end

  logic [7:0] store [NREG];
  logic       rd_pend_ff;
  logic       nxt_rd_pend;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  function automatic logic is_ro(input logic [5:0] a);
    return a <= grsa_pkg::RO_LAST;
  endfunction

  function automatic logic is_trig(input logic [5:0] a);
    return a == grsa_pkg::SOFT_RESTART;
  endfunction

  wire wr_take = i_avs_write & ~i_avs_read;
  wire wr_ok   = wr_take & ~is_ro(i_avs_address) & ~is_trig(i_avs_address)
                 & (i_avs_address != grsa_pkg::QUEUE_PORT);

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_cell
      localparam logic [7:0] MASK = (g == grsa_pkg::LATCH_CTRL)
                                    ? 8'h7F : 8'hFF;
      wire we = wr_ok & (i_avs_address == 6'(g));
      grsa_cell #(.WR_MASK(MASK)) u_cell (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_we    (we),
        .i_wdata (i_avs_writedata),
        .o_q     (store[g])
      );
    end
  endgenerate

  assign o_soft_restart = wr_take & (i_avs_address == grsa_pkg::SOFT_RESTART)
                          & (i_avs_writedata == grsa_pkg::SOFT_RESTART_KEY);
  assign o_latch_clear  = wr_take & (i_avs_address == grsa_pkg::LATCH_CTRL)
                          & i_avs_writedata[grsa_pkg::LATCH_CLR_BIT];

  // Read path: one wait cycle so read data comes from a flop
  assign nxt_rd_pend = i_avs_read & ~rd_pend_ff;
  assign o_avs_waitrequest = i_avs_read & ~rd_pend_ff;
  assign o_queue_pop = i_avs_read & rd_pend_ff & (i_avs_address == grsa_pkg::QUEUE_PORT);

  wire [7:0] rd_mux;
  assign rd_mux = is_ro(i_avs_address) ? i_status[i_avs_address[3:0]]
                : (i_avs_address == grsa_pkg::QUEUE_PORT) ? i_queue_data
                : is_trig(i_avs_address) ? 8'h00
                : store[i_avs_address];
  assign nxt_rdata = nxt_rd_pend ? rd_mux : rdata_ff;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rd_pend_ff <= 1'b0;
      rdata_ff   <= grsa_pkg::QUEUE_RESET;
    end else begin
      rd_pend_ff <= nxt_rd_pend;
      rdata_ff   <= nxt_rdata;
    end
  end

  assign o_avs_readdata = rdata_ff;

  // Assertions
  // Steps of a read: raised with no write, one stalled edge, then the answer
  sequence s_read_start;
    $rose(i_avs_read) && !i_avs_write;
  endsequence

  sequence s_read_answer;
    o_avs_waitrequest ##1 !o_avs_waitrequest;
  endsequence

  sequence s_write_to(logic [5:0] a);
    i_avs_write && i_avs_address == a;
  endsequence

  chk_ro_write_held: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_write_to(6'h05) |=> $stable(store[5]))
    else $error("read-only location changed");

  chk_trig_read_zero: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (i_avs_read && !o_avs_waitrequest && i_avs_address == grsa_pkg::SOFT_RESTART) |-> o_avs_readdata == 8'h00)
    else $error("trigger location read nonzero");

  chk_clear_bit_zero: assert property (
    @(posedge i_clk) disable iff (i_reset)
    store[grsa_pkg::LATCH_CTRL][7] == 1'b0)
    else $error("clear bit stored");

  chk_read_latency: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_read_start |-> s_read_answer)
    else $error("read answer not in one cycle");

  chk_write_stored: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (wr_ok && i_avs_address == 6'h10) |=> store[16] == $past(i_avs_writedata))
    else $error("write not stored");

  chk_write_nowait: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_avs_write |-> !o_avs_waitrequest)
    else $error("write stalled");

  chk_reserved_drop: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_write_to(grsa_pkg::LATCH_CTRL) |=> !store[grsa_pkg::LATCH_CTRL][7])
    else $error("reserved write kept");

  chk_latch_low_bits: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (wr_ok && i_avs_address == grsa_pkg::LATCH_CTRL)
    |=> store[grsa_pkg::LATCH_CTRL][6:0] == $past(i_avs_writedata[6:0]))
    else $error("writable bits lost");

  chk_pop_once: assert property (
    @(posedge i_clk) disable iff (i_reset)
    o_queue_pop |=> !o_queue_pop)
    else $error("double queue pop");

  chk_pop_on_answer: assert property (
    @(posedge i_clk) disable iff (i_reset)
    o_queue_pop |-> (i_avs_read && !o_avs_waitrequest && i_avs_address == grsa_pkg::QUEUE_PORT))
    else $error("pop outside a queue read");

  chk_write_no_pop: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_avs_write |-> !o_queue_pop)
    else $error("write popped the queue");

  chk_queue_port_held: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_write_to(grsa_pkg::QUEUE_PORT) |=> $stable(store[grsa_pkg::QUEUE_PORT]))
    else $error("queue port location changed");

  chk_read_capture: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_read_start |=> o_avs_readdata == $past(rd_mux))
    else $error("read byte not captured");

  chk_rdata_stands: assert property (
    @(posedge i_clk) disable iff (i_reset)
    !i_avs_read |=> $stable(o_avs_readdata))
    else $error("read data moved while idle");

  chk_idle_no_wait: assert property (
    @(posedge i_clk) disable iff (i_reset)
    !i_avs_read |-> !o_avs_waitrequest)
    else $error("stall without a read");

  chk_restart_key: assert property (
    @(posedge i_clk) disable iff (i_reset)
    o_soft_restart |-> (s_write_to(grsa_pkg::SOFT_RESTART) and i_avs_writedata == grsa_pkg::SOFT_RESTART_KEY))
    else $error("restart pulse without key");

  chk_latch_pulse: assert property (
    @(posedge i_clk) disable iff (i_reset)
    o_latch_clear |-> (i_avs_write && i_avs_address == grsa_pkg::LATCH_CTRL && i_avs_writedata[7]))
    else $error("clear pulse without clear bit");

  chk_restart_cell_idle: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_write_to(grsa_pkg::SOFT_RESTART) |=> $stable(store[grsa_pkg::SOFT_RESTART]))
    else $error("restart location stored a value");
endmodule

/* grsa_tb.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       i_clk = 0;
  logic       i_reset = 1;
  logic       rd = 0;
  logic       wr = 0;
  logic [5:0] adr = 0;
  logic [7:0] wd = 0;
  logic [7:0] qd = 0;
  logic [7:0] st [15];
  logic [7:0] rdat;
  logic       wt;
  logic       pop;
  logic       srst;
  logic       lclr;
  logic [7:0] exq [$];
  logic [7:0] d;
  logic [5:0] rw_addr [7] = '{6'h0F, 6'h10, 6'h13, 6'h15, 6'h20, 6'h22, 6'h3E};
  int         num_errors = 0;
  int         num_checks = 0;

  grsa_regs grsa_regs_inst (.i_clk(i_clk), .i_reset(i_reset), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat), .o_avs_waitrequest(wt),
    .i_status(st), .i_queue_data(qd), .o_queue_pop(pop), .o_soft_restart(srst), .o_latch_clear(lclr));

  initial forever #2.5 i_clk = ~i_clk;

  task automatic cmp(string n, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic end_of_test;
    if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // One idle edge before each request keeps a signal from being assigned twice in a step
  task automatic tx(logic w, logic [5:0] a, logic [7:0] v);
    int k;
    @(posedge i_clk);
    adr <= a;
    wd  <= v;
    wr  <= w;
    rd  <= !w;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (wt !== 1'b0 && k < 50);
    if (k >= 50) begin
      num_errors++;
      end_of_test;
    end else begin
      wr <= 0;
      rd <= 0;
    end
  endtask

  always @(posedge i_clk) if (!i_reset) begin
    if (rd && wt === 1'b0) begin
      cmp("readdata", exq.pop_front(), rdat);
      cmp("queue_pop", 8'(adr == grsa_pkg::QUEUE_PORT), 8'(pop));
    end
    if (wr) begin
      cmp("soft_restart", 8'(adr == grsa_pkg::SOFT_RESTART && wd == grsa_pkg::SOFT_RESTART_KEY), 8'(srst));
      cmp("latch_clear", 8'(adr == grsa_pkg::LATCH_CTRL && wd[7]), 8'(lclr));
    end
  end

  initial begin
    void'($urandom(27434));
    foreach (st[i]) st[i] = 8'($urandom);
    qd = 8'($urandom);
    repeat (12) @(posedge i_clk);
    i_reset <= 0;
    for (int a = 0; a < 15; a++) begin
      tx(1, 6'(a), ~st[a]);
      exq.push_back(st[a]);
      tx(0, 6'(a), 8'h00);
    end
    foreach (rw_addr[i]) begin
      d = 8'($urandom);
      tx(1, rw_addr[i], d);
      exq.push_back(d);
      tx(0, rw_addr[i], 8'h00);
    end
    tx(1, grsa_pkg::SOFT_RESTART, grsa_pkg::SOFT_RESTART_KEY);
    tx(1, grsa_pkg::SOFT_RESTART, 8'h5A);
    exq.push_back(8'h00);
    tx(0, grsa_pkg::SOFT_RESTART, 8'h00);
    tx(1, grsa_pkg::LATCH_CTRL, 8'hFF);
    exq.push_back(8'h7F);
    tx(0, grsa_pkg::LATCH_CTRL, 8'h00);
    tx(1, grsa_pkg::QUEUE_PORT, ~qd);
    exq.push_back(qd);
    tx(0, grsa_pkg::QUEUE_PORT, 8'h00);
    repeat (2) @(posedge i_clk);
    end_of_test;
  end
endmodule
